// [core/fpc_pkg.sv]
// Purpose: constants, types and carriers of the flash page command host
// Assumes: 100 MHz mclk; byte-wide strobed flash link
// Notes: timing counts derive from the ns figures and the clock rate
package fpc_pkg;
    // clock and link timing
    localparam int CLK_MHZ = 100;
    localparam int T_STROBE_LOW_NS = 30; // least strobe low time
    localparam int T_STROBE_HIGH_NS = 20; // least strobe high time
    localparam int T_BUSY_WAIT_NS = 100; // least wait before busy sampled
    localparam int T_STROBE_LOW_CYC = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int T_STROBE_HIGH_CYC =
        (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int T_BUSY_WAIT_CYC = (T_BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // partial program limit per page
    localparam logic [3:0] MAX_PARTIAL = 4'h8;
    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_MB_GO = 8'h31;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_PAGE_OUT = 8'h06;
    localparam logic [7:0] CMD_OUT_GO = 8'hE0;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_COL_IN = 8'h85;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    // address byte layout: column low, column high, row low, row high
    localparam int COL_W = 12;
    localparam int PAGE_W = 14;
    localparam int BANK_W = 2;
    localparam int LEN_W = 12;
    localparam logic [1:0] ADDR_LAST_COL = 2'h1;
    localparam logic [1:0] ADDR_LAST_ROW = 2'h3;
    // requested operations
    typedef enum logic [2:0] {
        FPC_OP_READ = 3'h0,
        FPC_OP_MB_LOAD = 3'h1,
        FPC_OP_MB_GO = 3'h2,
        FPC_OP_PAGE_OUT = 3'h3,
        FPC_OP_COL_OUT = 3'h4,
        FPC_OP_PROG_LOAD = 3'h5,
        FPC_OP_COL_IN = 3'h6,
        FPC_OP_PROG_GO = 3'h7
    } fpc_op_t;
    // one request from the user side
    typedef struct packed {
        fpc_op_t op;
        logic [BANK_W-1:0] bank;
        logic [PAGE_W-1:0] page;
        logic [COL_W-1:0] col;
        logic [LEN_W-1:0] len;
        logic erased;
    } fpc_req_t;
    // pins driven toward the flash
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic io_oe;
        logic [7:0] io_out;
    } fpc_pins_t;
endpackage

// [core/fpc_host.sv]
// Purpose: host sequencer for page read, multi-bank read and page program
// Assumes: one clock mclk, asynchronous active-high rst
// Notes: one request at a time; data bytes stream through wr_/rd_ ports
//
// Operation
// R1: read is 00h, four address bytes, 30h; device then goes busy.
// R2: after ready, each read strobe fall yields the next byte.
// R3: device pre-loads following three bank pages on a first read.
// R4: host fetches pre-loaded pages with the page-data-out command.
// R5: column jump during read output is 05h, two column bytes, E0h.
// R6: device accepts column jumps in any order, repeatedly.
// R7: multi-bank setup is 00h plus four address bytes per bank.
// R8: device keeps only the latest page address given per bank.
// R9: 31h closes multi-bank setup and starts the array transfers.
// R10: bank output is selected by 06h, four address bytes, E0h.
// R11: device allows any loaded bank to be read again repeatedly.
// R12: column jump in multi-bank output is 05h, two columns, E0h.
// R13: program is 80h, four address bytes, then data bytes.
// R14: 10h confirms program and starts automatic programming.
// R15: host programs only pages known to be erased; after reset the code also accepts bank 0 page 0 with erased low.
// R16: host programs one page at most eight times before erase.
// R17: 85h with two column bytes redirects program data input.
// R18: at least one data byte follows each input redirection.
// R19: commands use cle, addresses ale, data neither, on we_n rise.
// R20: device busy during transfers; host reads nothing until ready.
`timescale 1ns/1ns
module fpc_host #(
    parameter int T_LOW = fpc_pkg::T_STROBE_LOW_CYC,
    parameter int T_HIGH = fpc_pkg::T_STROBE_HIGH_CYC,
    parameter int T_WB = fpc_pkg::T_BUSY_WAIT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    input wire fpc_pkg::fpc_req_t req,
    output logic req_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic err,
    output fpc_pkg::fpc_pins_t pins,
    input wire logic [7:0] io_in,
    input wire logic rb_n
);
    // refuse counts the counter cannot hold
    if (T_LOW < 1 || T_HIGH < 1 || T_WB < 1 || T_LOW > 255 ||
        T_HIGH > 255 || T_WB > 255) begin : g_bad_timing
        $error("fpc_host: timing counts must lie in 1..255");
    end

    localparam logic [7:0] LOW_M1 = 8'(T_LOW - 1);
    localparam logic [7:0] HIGH_M1 = 8'(T_HIGH - 1);
    localparam logic [7:0] WB_M1 = 8'(T_WB - 1);

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_CMD1 = 6'b00_0010,
        ST_ADDR = 6'b00_0100,
        ST_CMD2 = 6'b00_1000,
        ST_WAITB = 6'b01_0000,
        ST_DATA = 6'b10_0000
    } fpc_state_t;
    typedef enum logic [2:0] {
        PH_SU = 3'b001,
        PH_LO = 3'b010,
        PH_HI = 3'b100
    } fpc_phase_t;

    fpc_state_t state, next_state;
    fpc_phase_t ph, next_ph;
    fpc_pkg::fpc_req_t cur, next_cur;
    fpc_pkg::fpc_pins_t next_pins;
    logic [7:0] cnt, next_cnt;
    logic [1:0] aidx, next_aidx;
    logic [fpc_pkg::LEN_W-1:0] bcnt, next_bcnt;
    logic [2:0] rb_q;
    logic rb_ok, next_rb_ok;
    logic prog_open, next_prog_open;
    logic [3:0] prog_cnt, next_prog_cnt;
    logic [15:0] prog_row, next_prog_row;
    logic next_req_ready, next_wr_ready, next_rd_valid, next_done, next_err;
    logic [7:0] next_rd_data;
    // decoded shape of the current operation
    logic [7:0] c1, c2;
    logic has_addr, last_col, has_c2, wait_busy, dir_rd, dir_wr;
    logic [15:0] row;

    // operation shape of the held request
    always_comb begin
        c1 = fpc_pkg::CMD_READ;
        c2 = fpc_pkg::CMD_OUT_GO;
        has_addr = 1'b1;
        last_col = 1'b0;
        has_c2 = 1'b0;
        wait_busy = 1'b0;
        dir_rd = 1'b0;
        dir_wr = 1'b0;
        row = {cur.bank, cur.page};
        case (cur.op)
            fpc_pkg::FPC_OP_READ: begin
                c2 = fpc_pkg::CMD_READ_GO; // [R1]
                has_c2 = 1'b1;
                wait_busy = 1'b1;
                dir_rd = 1'b1;
            end
            fpc_pkg::FPC_OP_MB_LOAD: ; // [R7] one bank per request
            fpc_pkg::FPC_OP_MB_GO: begin
                c1 = fpc_pkg::CMD_MB_GO; // [R9]
                has_addr = 1'b0;
                wait_busy = 1'b1;
            end
            fpc_pkg::FPC_OP_PAGE_OUT: begin
                c1 = fpc_pkg::CMD_PAGE_OUT; // [R4] [R10]
                has_c2 = 1'b1;
                dir_rd = 1'b1;
            end
            fpc_pkg::FPC_OP_COL_OUT: begin
                c1 = fpc_pkg::CMD_COL_OUT; // [R5] [R12]
                last_col = 1'b1;
                has_c2 = 1'b1;
                dir_rd = 1'b1;
            end
            fpc_pkg::FPC_OP_PROG_LOAD: begin
                c1 = fpc_pkg::CMD_PROG; // [R13]
                dir_wr = 1'b1;
            end
            fpc_pkg::FPC_OP_COL_IN: begin
                c1 = fpc_pkg::CMD_COL_IN; // [R17]
                last_col = 1'b1;
                dir_wr = 1'b1;
            end
            fpc_pkg::FPC_OP_PROG_GO: begin
                c1 = fpc_pkg::CMD_PROG_GO; // [R14]
                has_addr = 1'b0;
                wait_busy = 1'b1;
            end
            default: ;
        endcase
    end

    // sequencer next values
    always_comb begin
        logic slot_end;
        logic after_cmd;
        logic to_data;
        logic legal;
        slot_end = 1'b0;
        after_cmd = 1'b0;
        to_data = 1'b0;
        legal = 1'b1;
        next_state = state;
        next_ph = ph;
        next_cur = cur;
        next_pins = pins;
        next_cnt = cnt;
        next_aidx = aidx;
        next_bcnt = bcnt;
        next_prog_open = prog_open;
        next_prog_cnt = prog_cnt;
        next_prog_row = prog_row;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        next_done = 1'b0;
        next_err = 1'b0;
        next_wr_ready = 1'b0;
        // busy input counts once the last two stages agree
        next_rb_ok = (rb_q[1] == rb_q[2]) ? rb_q[2] : rb_ok;
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    case (req.op)
                        fpc_pkg::FPC_OP_PROG_LOAD: // [R15] [R16]
                            legal = req.erased ||
                                ({req.bank, req.page} == prog_row &&
                                 prog_cnt < fpc_pkg::MAX_PARTIAL);
                        fpc_pkg::FPC_OP_COL_IN: // [R18]
                            legal = prog_open && (req.len != '0);
                        fpc_pkg::FPC_OP_PROG_GO: legal = prog_open;
                        default: legal = 1'b1;
                    endcase
                    next_err = !legal;
                    if (legal) begin
                        next_cur = req;
                        next_state = ST_CMD1;
                        next_ph = PH_SU;
                        next_pins.ce_n = 1'b0;
                        if (req.op == fpc_pkg::FPC_OP_PROG_LOAD) begin
                            next_prog_open = 1'b1;
                            next_prog_row = {req.bank, req.page};
                            if (req.erased) begin
                                next_prog_cnt = 4'h0;
                            end
                        end
                        if (req.op == fpc_pkg::FPC_OP_PROG_GO) begin
                            next_prog_open = 1'b0;
                            next_prog_cnt = prog_cnt + 4'h1; // [R16]
                        end
                    end
                end
            end
            ST_CMD1, ST_ADDR, ST_CMD2, ST_DATA: begin
                case (ph)
                    PH_SU: begin
                        if (!(state == ST_DATA && dir_wr)) begin
                            next_ph = PH_LO;
                            next_cnt = LOW_M1;
                            next_pins.we_n = dir_rd && state == ST_DATA;
                            next_pins.read_strobe_n =
                                !(dir_rd && state == ST_DATA); // [R2]
                        end else if (wr_valid && wr_ready) begin
                            next_pins.io_out = wr_data;
                            next_pins.we_n = 1'b0;
                            next_ph = PH_LO;
                            next_cnt = LOW_M1;
                        end else begin
                            next_wr_ready = 1'b1;
                        end
                    end
                    PH_LO: begin
                        if (cnt != 8'h00) begin
                            next_cnt = cnt - 8'h01;
                        end else begin
                            next_pins.we_n = 1'b1; // [R19] latch on rise
                            next_pins.read_strobe_n = 1'b1;
                            if (state == ST_DATA && dir_rd) begin
                                next_rd_data = io_in;
                                next_rd_valid = 1'b1;
                            end
                            next_ph = PH_HI;
                            next_cnt = HIGH_M1;
                        end
                    end
                    PH_HI: begin
                        if (cnt != 8'h00) begin
                            next_cnt = cnt - 8'h01;
                        end else begin
                            slot_end = 1'b1;
                        end
                    end
                    default: next_ph = PH_SU;
                endcase
            end
            ST_WAITB: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else if (rb_ok) begin // [R20]
                    to_data = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // advance after a finished byte slot
        if (slot_end) begin
            next_ph = PH_SU;
            case (state)
                ST_CMD1: begin
                    if (has_addr) begin
                        next_state = ST_ADDR;
                        next_aidx = 2'h0;
                    end else begin
                        after_cmd = 1'b1;
                    end
                end
                ST_ADDR: begin
                    if (aidx != (last_col ? fpc_pkg::ADDR_LAST_COL
                                          : fpc_pkg::ADDR_LAST_ROW)) begin
                        next_aidx = aidx + 2'h1;
                    end else if (has_c2) begin
                        next_state = ST_CMD2;
                    end else begin
                        after_cmd = 1'b1;
                    end
                end
                ST_CMD2: after_cmd = 1'b1;
                default: begin
                    next_bcnt = bcnt - 1'b1;
                    if (bcnt == 12'h001) begin
                        next_state = ST_IDLE;
                    end
                end
            endcase
        end
        if (after_cmd) begin
            if (wait_busy) begin
                next_state = ST_WAITB;
                next_cnt = WB_M1;
            end else begin
                to_data = 1'b1;
            end
        end
        if (to_data) begin
            next_bcnt = cur.len;
            next_ph = PH_SU;
            next_state = ((dir_rd || dir_wr) && cur.len != '0) ? ST_DATA
                                                               : ST_IDLE;
        end
        // set up the pins of the coming slot
        next_pins.cle = 1'b0;
        next_pins.ale = 1'b0;
        next_pins.io_oe = 1'b0;
        if (next_state == ST_CMD1 || next_state == ST_CMD2) begin
            next_pins.cle = 1'b1; // [R19]
            next_pins.io_oe = 1'b1;
            if (next_ph == PH_SU) begin
                next_pins.io_out = (next_state == ST_CMD1) ? c1 : c2;
                if (state == ST_IDLE) begin
                    next_pins.io_out = 8'h00; // patched below from req
                end
            end
        end else if (next_state == ST_ADDR) begin
            next_pins.ale = 1'b1; // [R19]
            next_pins.io_oe = 1'b1;
            case (next_aidx)
                2'h0: next_pins.io_out = cur.col[7:0];
                2'h1: next_pins.io_out = {4'h0, cur.col[11:8]};
                2'h2: next_pins.io_out = row[7:0];
                default: next_pins.io_out = row[15:8];
            endcase
        end else if (next_state == ST_DATA) begin
            next_pins.io_oe = dir_wr;
        end
        if (next_state == ST_IDLE && state != ST_IDLE) begin
            next_pins.ce_n = 1'b1;
            next_done = 1'b1;
        end
        next_req_ready = (next_state == ST_IDLE);
    end

    // first command byte comes from the new request, not the held one
    logic [7:0] start_code;
    always_comb begin
        case (req.op)
            fpc_pkg::FPC_OP_MB_GO: start_code = fpc_pkg::CMD_MB_GO;
            fpc_pkg::FPC_OP_PAGE_OUT: start_code = fpc_pkg::CMD_PAGE_OUT;
            fpc_pkg::FPC_OP_COL_OUT: start_code = fpc_pkg::CMD_COL_OUT;
            fpc_pkg::FPC_OP_PROG_LOAD: start_code = fpc_pkg::CMD_PROG;
            fpc_pkg::FPC_OP_COL_IN: start_code = fpc_pkg::CMD_COL_IN;
            fpc_pkg::FPC_OP_PROG_GO: start_code = fpc_pkg::CMD_PROG_GO;
            default: start_code = fpc_pkg::CMD_READ;
        endcase
    end

    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            ph <= PH_SU;
            cur <= '0;
            pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                      read_strobe_n: 1'b1, io_oe: 1'b0, io_out: 8'h00};
            cnt <= 8'h00;
            aidx <= 2'h0;
            bcnt <= '0;
            rb_q <= 3'h0;
            rb_ok <= 1'b0;
            prog_open <= 1'b0;
            prog_cnt <= 4'h0;
            prog_row <= 16'h0000;
            req_ready <= 1'b1;
            wr_ready <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            err <= 1'b0;
        end else begin
            state <= next_state;
            ph <= next_ph;
            cur <= next_cur;
            pins <= next_pins;
            if (state == ST_IDLE && next_state == ST_CMD1) begin
                pins.io_out <= start_code;
            end
            cnt <= next_cnt;
            aidx <= next_aidx;
            bcnt <= next_bcnt;
            rb_q <= {rb_q[1:0], rb_n};
            rb_ok <= next_rb_ok;
            prog_open <= next_prog_open;
            prog_cnt <= next_prog_cnt;
            prog_row <= next_prog_row;
            req_ready <= next_req_ready;
            wr_ready <= next_wr_ready;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            done <= next_done;
            err <= next_err;
        end
    end

    // checks
    chk_latch_exclusive: assert property (@(posedge mclk) disable iff (rst)
        !pins.we_n |-> !pins.ce_n && !(pins.cle && pins.ale)) // [R19]
        else $error("write strobe with bad latch levels");
    chk_read_confirm: assert property (@(posedge mclk) disable iff (rst)
        state == ST_CMD2 && cur.op == fpc_pkg::FPC_OP_READ && !pins.we_n
        |-> pins.io_out == fpc_pkg::CMD_READ_GO) // [R1]
        else $error("read not confirmed with 30h");
    chk_no_read_busy: assert property (@(posedge mclk) disable iff (rst)
        $fell(pins.read_strobe_n) |-> rb_ok && !pins.io_oe) // [R20]
        else $error("read strobe while busy or driving");
    chk_strobe_width: assert property (@(posedge mclk) disable iff (rst)
        $fell(pins.read_strobe_n) |-> !pins.read_strobe_n[*3]) // [R2]
        else $error("read strobe low too short");
    chk_jump_confirm: assert property (@(posedge mclk) disable iff (rst)
        state == ST_CMD2 && cur.op == fpc_pkg::FPC_OP_COL_OUT && !pins.we_n
        |-> pins.io_out == fpc_pkg::CMD_OUT_GO && $past(aidx) == 2'h1)
        else $error("column jump not closed by E0h"); // [R5] [R12]
    chk_addr_four: assert property (@(posedge mclk) disable iff (rst)
        $fell(state == ST_ADDR) && cur.op == fpc_pkg::FPC_OP_MB_LOAD
        |-> $past(aidx) == 2'h3) // [R7]
        else $error("bank setup without four address bytes");
    chk_prog_erased: assert property (@(posedge mclk) disable iff (rst)
        state == ST_IDLE && req_valid && !req.erased &&
        req.op == fpc_pkg::FPC_OP_PROG_LOAD &&
        {req.bank, req.page} != prog_row |=> err) // [R15]
        else $error("program of unknown page not refused");
    chk_prog_limit: assert property (@(posedge mclk) disable iff (rst)
        prog_cnt <= fpc_pkg::MAX_PARTIAL) // [R16]
        else $error("page programmed more than allowed");
    chk_redirect_byte: assert property (@(posedge mclk) disable iff (rst)
        $rose(state == ST_CMD1) && cur.op == fpc_pkg::FPC_OP_COL_IN
        |-> cur.len != '0) // [R18]
        else $error("redirection without data byte");
    chk_prog_confirm: assert property (@(posedge mclk) disable iff (rst)
        $rose(state == ST_WAITB) && cur.op == fpc_pkg::FPC_OP_PROG_GO
        |-> $past(pins.io_out, 2) == fpc_pkg::CMD_PROG_GO) // [R14]
        else $error("program wait without 10h");
endmodule // fpc_host

// [test/fpc_flash_model.sv]
// Purpose: behavioural flash device facing the host sequencer
// Assumes: bytes latched on we_n rise; array holds a fixed pattern
// Notes: counters are read by the bench to judge device events
`timescale 1ns/1ns
module fpc_flash_model #(parameter int BUSY = 30) (
    input wire logic mclk,
    input wire fpc_pkg::fpc_pins_t pins,
    output logic [7:0] io_in,
    output logic rb_n
);
    logic [7:0] cmd, wbuf[4096], ab[4];
    logic [13:0] rpage[4], pend[4];
    logic [3:0] pv = 4'h0;
    logic [1:0] cur = 2'h0;
    logic [11:0] ptr;
    logic [15:0] prow;
    int na = 0, busy = 0, nbusy = 0, nprog = 0, proto_err = 0;
    int early_rd = 0;
    // array content per bank, page and column
    function automatic logic [7:0] arr(logic [1:0] b, logic [13:0] p,
        logic [11:0] c);
        return p[7:0] ^ c[7:0] ^ {b, 6'h15};
    endfunction
    // command decode
    task automatic take_cmd(input logic [7:0] c);
        if (c == 8'h30 || c == 8'h31 || c == 8'h10) begin
            busy = BUSY;
            nbusy++;
        end
        if (c == 8'h30) begin
            cur = ab[3][7:6];
            rpage[cur] = {ab[3][5:0], ab[2]};
            rpage[cur + 2'h1] = {ab[3][5:0], ab[2]};
            rpage[cur + 2'h2] = {ab[3][5:0], ab[2]};
            rpage[cur + 2'h3] = {ab[3][5:0], ab[2]};
        end
        for (int k = 0; k < 4; k++) begin
            if (c == 8'h31 && pv[k]) rpage[k] = pend[k];
        end
        if (c == 8'h30 || c == 8'h31) pv = 4'h0;
        if (c == 8'h10) prow = {ab[3], ab[2]};
        if (c == 8'h10) nprog++;
        if (c == 8'hE0 && cmd == 8'h06) cur = ab[3][7:6];
        if (c != 8'hE0 && c != 8'h30 && c != 8'h31 && c != 8'h10) cmd = c;
        na = 0;
    endtask
    // one byte per we_n rise, kind by latch enables
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.cle && pins.ale) begin
            proto_err++;
        end else if (!pins.ce_n && pins.cle) begin
            take_cmd(pins.io_out);
        end else if (!pins.ce_n && pins.ale) begin
            if (na < 4) ab[na] = pins.io_out;
            na++;
            if (na == 2) ptr = {ab[1][3:0], ab[0]};
            if (na == 4 && cmd == 8'h00) pend[ab[3][7:6]] = {ab[3][5:0], ab[2]};
            if (na == 4 && cmd == 8'h00) pv[ab[3][7:6]] = 1'b1;
        end else if (!pins.ce_n) begin
            wbuf[ptr] = pins.io_out;
            ptr++;
        end
    end
    // busy time counted on the system clock
    always @(posedge mclk) begin
        if (busy > 0) busy--;
        // non-blocking so the host samples the value of the previous edge
        rb_n <= (busy == 0);
    end
    // each strobe fall puts out the next register byte
    always @(negedge pins.read_strobe_n) begin
        if (!rb_n) early_rd++;
        io_in = arr(cur, rpage[cur], ptr);
        ptr++;
    end
    // a released bus never shows the last byte
    always @(posedge pins.read_strobe_n) io_in = ~io_in;
endmodule // fpc_flash_model

// [test/fpc_host_tb.sv]
// Purpose: self-checking bench of the flash page command host
// Assumes: flash model on the pins; default strobe timing
// Notes: expected bytes come from the model's fixed array pattern
`timescale 1ns/1ns
module fpc_host_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    fpc_pkg::fpc_req_t req = '0;
    logic [7:0] wr_data = 8'h00;
    logic wr_valid = 1'b0;
    logic req_ready, rd_valid, done, err, rb_n, wr_ready;
    logic [7:0] rd_data, io_in, rq[$], wq[$];
    fpc_pkg::fpc_pins_t pins;
    logic e;
    int wi, n0, bad_count = 0, num_checks = 0;
    // system clock
    always #5 mclk = ~mclk;
    fpc_host i_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .err(err), .pins(pins),
        .io_in(io_in), .rb_n(rb_n));
    fpc_flash_model i_flash (.mclk(mclk), .pins(pins), .io_in(io_in),
        .rb_n(rb_n));
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request; read bytes gathered, wq bytes streamed
    task automatic do_op(input fpc_pkg::fpc_op_t op, input logic [1:0] b,
        input logic [13:0] pg, input logic [11:0] c, input logic [11:0] n,
        input logic er);
        int k;
        rq.delete();
        wi = 0;
        @(posedge mclk);
        req <= '{op: op, bank: b, page: pg, col: c, len: n, erased: er};
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        wr_valid <= (wq.size() > 0);
        if (wq.size() > 0) wr_data <= wq[0];
        for (k = 0; k < 20000; k++) begin
            @(posedge mclk);
            if (rd_valid === 1'b1) rq.push_back(rd_data);
            if (wr_valid && wr_ready === 1'b1) begin
                wi++;
                wr_valid <= (wi < wq.size());
                if (wi < wq.size()) wr_data <= wq[wi];
            end
            if (done === 1'b1 || err === 1'b1) break;
        end
        e = err;
        wr_valid <= 1'b0;
        wq.delete();
        if (k == 20000) bad_count++;
        if (k == 20000) final_report();
    endtask
    // read bytes against the array pattern
    task automatic chk_rd(input logic [1:0] b, input logic [13:0] p,
        input logic [11:0] c, input int n);
        chk(rq.size(), n);
        foreach (rq[i]) chk(rq[i], i_flash.arr(b, p, c + 12'(i)));
    endtask
    task automatic t_read();
        n0 = i_flash.nbusy;
        do_op(fpc_pkg::FPC_OP_READ, 2'h1, 14'h0005, 12'h00a, 12'h004, 1'b0);
        chk_rd(2'h1, 14'h0005, 12'h00a, 4);
        chk(i_flash.nbusy, n0 + 1);
        do_op(fpc_pkg::FPC_OP_COL_OUT, 2'h0, 14'h0000, 12'h003, 12'h002, 1'b0);
        chk_rd(2'h1, 14'h0005, 12'h003, 2);
        do_op(fpc_pkg::FPC_OP_COL_OUT, 2'h0, 14'h0000, 12'h003, 12'h001, 1'b0);
        chk_rd(2'h1, 14'h0005, 12'h003, 1);
        do_op(fpc_pkg::FPC_OP_PAGE_OUT, 2'h2, 14'h0000, 12'h000, 12'h002, 1'b0);
        chk_rd(2'h2, 14'h0005, 12'h000, 2);
    endtask
    task automatic t_mb();
        do_op(fpc_pkg::FPC_OP_MB_LOAD, 2'h3, 14'h0007, 12'h000, 12'h000, 1'b0);
        do_op(fpc_pkg::FPC_OP_MB_LOAD, 2'h3, 14'h0009, 12'h000, 12'h000, 1'b0);
        do_op(fpc_pkg::FPC_OP_MB_LOAD, 2'h0, 14'h0002, 12'h000, 12'h000, 1'b0);
        do_op(fpc_pkg::FPC_OP_MB_GO, 2'h0, 14'h0000, 12'h000, 12'h000, 1'b0);
        for (int r = 0; r < 2; r++) begin
            do_op(fpc_pkg::FPC_OP_PAGE_OUT, 2'h3, 14'h0000, 12'h001, 12'h002, 1'b0);
            chk_rd(2'h3, 14'h0009, 12'h001, 2);
        end
        do_op(fpc_pkg::FPC_OP_PAGE_OUT, 2'h0, 14'h0000, 12'h000, 12'h001, 1'b0);
        chk_rd(2'h0, 14'h0002, 12'h000, 1);
        do_op(fpc_pkg::FPC_OP_COL_OUT, 2'h0, 14'h0000, 12'h007, 12'h001, 1'b0);
        chk_rd(2'h0, 14'h0002, 12'h007, 1);
    endtask
    task automatic t_prog();
        n0 = i_flash.nprog;
        wq = '{8'ha1, 8'hb2, 8'hc3};
        do_op(fpc_pkg::FPC_OP_PROG_LOAD, 2'h0, 14'h0004, 12'h008, 12'h003, 1'b1);
        do_op(fpc_pkg::FPC_OP_COL_IN, 2'h0, 14'h0000, 12'h014, 12'h000, 1'b0);
        chk(e, 1'b1);
        wq = '{8'h5a};
        do_op(fpc_pkg::FPC_OP_COL_IN, 2'h0, 14'h0000, 12'h014, 12'h001, 1'b0);
        do_op(fpc_pkg::FPC_OP_PROG_GO, 2'h0, 14'h0000, 12'h000, 12'h000, 1'b0);
        chk({i_flash.wbuf[8], i_flash.wbuf[9], i_flash.wbuf[10]}, 32'h00a1_b2c3);
        chk(i_flash.wbuf[20], 8'h5a);
        chk(i_flash.prow, 16'h0004);
        chk(i_flash.nprog, n0 + 1);
    endtask
    task automatic t_refuse();
        do_op(fpc_pkg::FPC_OP_PROG_LOAD, 2'h0, 14'h0006, 12'h000, 12'h001, 1'b0);
        chk(e, 1'b1);
        do_op(fpc_pkg::FPC_OP_COL_IN, 2'h0, 14'h0000, 12'h000, 12'h001, 1'b0);
        chk(e, 1'b1);
        do_op(fpc_pkg::FPC_OP_PROG_GO, 2'h0, 14'h0000, 12'h000, 12'h000, 1'b0);
        chk(e, 1'b1);
        for (int r = 0; r < 8; r++) begin
            wq = '{8'h3c};
            do_op(fpc_pkg::FPC_OP_PROG_LOAD, 2'h0, 14'h0004, 12'h000, 12'h001, 1'b0);
            chk(e, (r == 7));
            if (r < 7) do_op(fpc_pkg::FPC_OP_PROG_GO, 2'h0, 14'h0000, 12'h000, 12'h000, 1'b0);
        end
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_read();
        t_mb();
        t_prog();
        t_refuse();
        chk(i_flash.early_rd, 0);
        chk(i_flash.proto_err, 0);
        final_report();
    end
endmodule // fpc_host_tb
